//--- src/pcmc_pkg.sv
// Package of constants and types for the PCM compander and power control block
`default_nettype none
package pcmc_pkg;
  // ********************************
  // Code word layout
  // ********************************
  localparam int unsigned LIN_W = 13;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned SIGN_POS = 7;
  localparam int unsigned CHORD_POS = 4;
  localparam int unsigned CHORD_W = 3;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned NUM_CHORDS = 8;
  // Mu-255 bias in 14-bit magnitude units and A-law even-bit inversion mask
  localparam logic [13:0] MU_BIAS = 14'h0021;
  localparam logic [7:0] MU_INV_MASK = 8'hff;
  localparam logic [7:0] A_INV_MASK = 8'h55;
  // ********************************
  // Timing
  // ********************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FRAME_US = 125;
  localparam int unsigned FRAME_CYCLES = FRAME_US * CLK_MHZ;
  localparam logic [1:0] PWRUP_FRAMES = 2'h2;
  localparam logic [3:0] IDLE_FRAMES = 4'h4;
  localparam logic [4:0] BIT_CYCLES = 5'h10;
  // ********************************
  // Power states
  // ********************************
  typedef enum logic [1:0] {PCMC_OFF, PCMC_WAKE, PCMC_RUN} pcmc_pwr_e;
endpackage
`default_nettype wire

//--- src/pcm_compander.sv
// Companding encoder, decoder, transmit shifter and power-down sequencing
`default_nettype none
module pcm_compander
  import pcmc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pins from the highway, asynchronous
  input wire logic law_select,
  input wire logic power_down_n,
  input wire logic tx_frame_sync,
  input wire logic rx_frame_sync,
  // Linear sample from the converter side
  input wire logic [LIN_W-1:0] txSample,
  // Code received from the highway, one per receive frame
  input wire logic [CODE_W-1:0] rxCode,
  // Decoded linear sample
  output logic [LIN_W-1:0] rxSample,
  output logic rxSampleValid,
  // Transmit serial pin, two signals
  output logic tx_pcm_out,
  output logic txPcmOe,
  // Status
  output logic poweredUp
);
  // ********************************
  // Input synchronisers
  // ********************************
  logic [1:0] s1_ff, s2_ff, s3_ff, s4_ff;
  logic lawMu, pdnN, fsTx, fsRx;
  // Two stages each; only the second stage feeds logic
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
      s3_ff <= 2'h0;
      s4_ff <= 2'h0;
    end else begin
      s1_ff <= {s1_ff[0], law_select};
      s2_ff <= {s2_ff[0], power_down_n};
      s3_ff <= {s3_ff[0], tx_frame_sync};
      s4_ff <= {s4_ff[0], rx_frame_sync};
    end
  end
  assign lawMu = s1_ff[1];
  assign pdnN = s2_ff[1];
  assign fsTx = s3_ff[1];
  assign fsRx = s4_ff[1];

  // ********************************
  // Encoder and decoder functions
  // ********************************
  // Linear to code, magnitude scaled to 14 bits for both laws
  function automatic logic [7:0] encode(input logic mu, input logic [12:0] lin);
    logic [13:0] mag;
    logic [2:0] chord;
    logic [3:0] step;
    logic [7:0] raw;
    // A-law folds negatives by one's complement, so the most negative sample cannot overflow
    mag = lin[12] ? (mu ? 14'((~{lin[12], lin}) + 14'h1) : {1'b0, ~lin}) : {1'b0, lin};
    mag = {mag[12:0], 1'b0};
    if (mu) begin
      mag = (mag > 14'h1fde) ? 14'h1fff : 14'(mag + MU_BIAS);
    end
    chord = 3'h0;
    for (int i = 1; i < NUM_CHORDS; i++) begin
      if (mag[i+5]) begin
        chord = 3'(i);
      end
    end
    // Shift amount widened so the top chord does not wrap to zero
    if (mu) begin
      step = 4'(mag >> (4'(chord) + 4'h1));
    end else begin
      step = (chord == 3'h0) ? mag[5:2] : 4'(mag >> (4'(chord) + 4'h1));
    end
    // Positive ends up with the sign set after either inversion mask
    raw = {lin[12] ^ !mu, chord, step};
    encode = raw ^ (mu ? MU_INV_MASK : (A_INV_MASK | 8'h00));
  endfunction

  // Code to linear, 13-bit two's complement
  function automatic logic [12:0] decode(input logic mu, input logic [7:0] code);
    logic [7:0] c;
    logic [13:0] mag;
    c = code ^ (mu ? MU_INV_MASK : A_INV_MASK);
    if (mu) begin
      mag = 14'((({10'h0, c[3:0]} << 1) + MU_BIAS) << c[6:4]) - MU_BIAS;
    end else if (c[6:4] == 3'h0) begin
      mag = {8'h0, c[3:0], 2'h2};
    end else begin
      mag = 14'(({9'h0, 1'b1, c[3:0], 1'b1} << 1) << (c[6:4] - 3'h1));
    end
    mag = {1'b0, mag[13:1]};
    // Mu mask flips the sign bit as well, so its sense is inverted here
    decode = (c[SIGN_POS] ^ mu) ? mag[12:0] : 13'((~mag[12:0]) + 13'h1);
  endfunction

  // ********************************
  // Power sequencing
  // ********************************
  pcmc_pwr_e pwr_ff, nxt_pwr;
  logic [1:0] wakeCnt_ff, nxt_wakeCnt;
  logic [3:0] idleCnt_ff, nxt_idleCnt;
  logic [13:0] frmCnt_ff, nxt_frmCnt;
  logic fsTxD_ff, fsRxD_ff, frameTick, clkEn;
  // Gated clock modelled as an enable: while off the bit and divider counts clear and the rest of the datapath holds, but the idle detector still counts
  assign clkEn = (pwr_ff != PCMC_OFF);
  assign frameTick = fsTx & ~fsTxD_ff;
  // Idle detector counts 125 us windows with neither sync high
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_wakeCnt = wakeCnt_ff;
    nxt_idleCnt = idleCnt_ff;
    nxt_frmCnt = frmCnt_ff;
    if ((fsTx | fsRx) || !pdnN) begin
      nxt_idleCnt = 4'h0;
      nxt_frmCnt = 14'h0;
    end else if (frmCnt_ff == 14'(FRAME_CYCLES - 1)) begin
      nxt_frmCnt = 14'h0;
      if (idleCnt_ff != IDLE_FRAMES) begin
        nxt_idleCnt = idleCnt_ff + 4'h1;
      end
    end else begin
      nxt_frmCnt = frmCnt_ff + 14'h1;
    end
    case (pwr_ff)
      PCMC_OFF: begin
        nxt_wakeCnt = 2'h0;
        if (pdnN && (fsTx | fsRx)) begin
          nxt_pwr = PCMC_WAKE;
        end
      end
      PCMC_WAKE: begin
        if (frameTick) begin
          nxt_wakeCnt = wakeCnt_ff + 2'h1;
          if (wakeCnt_ff == PWRUP_FRAMES) begin
            nxt_pwr = PCMC_RUN;
          end
        end
      end
      PCMC_RUN: ;
      default: nxt_pwr = PCMC_OFF;
    endcase
    if (!pdnN || (idleCnt_ff == IDLE_FRAMES)) begin
      nxt_pwr = PCMC_OFF;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwr_ff <= PCMC_OFF;
      wakeCnt_ff <= 2'h0;
      idleCnt_ff <= 4'h0;
      frmCnt_ff <= 14'h0;
      fsTxD_ff <= 1'b0;
      fsRxD_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      wakeCnt_ff <= nxt_wakeCnt;
      idleCnt_ff <= nxt_idleCnt;
      frmCnt_ff <= nxt_frmCnt;
      fsTxD_ff <= fsTx;
      fsRxD_ff <= fsRx;
    end
  end
  assign poweredUp = (pwr_ff == PCMC_RUN);

  // ********************************
  // Transmit and receive datapath
  // ********************************
  logic [7:0] sh_ff, nxt_sh;
  logic [3:0] bits_ff, nxt_bits;
  logic [4:0] div_ff, nxt_div;
  logic [12:0] rxS_ff, nxt_rxS;
  logic rxV_ff, nxt_rxV;
  // Capture at frame start, then shift MSB first, one bit per 16 cycles
  always_comb begin
    nxt_sh = sh_ff;
    nxt_bits = bits_ff;
    nxt_div = div_ff;
    nxt_rxS = rxS_ff;
    nxt_rxV = 1'b0;
    if (!clkEn) begin
      nxt_bits = 4'h0;
      nxt_div = 5'h0;
    end else if (frameTick) begin
      nxt_sh = encode(lawMu, txSample);
      nxt_bits = (pwr_ff == PCMC_RUN) ? 4'h8 : 4'h0;
      nxt_div = 5'h0;
    end else if (bits_ff != 4'h0) begin
      if (div_ff == BIT_CYCLES - 5'h1) begin
        nxt_div = 5'h0;
        nxt_bits = bits_ff - 4'h1;
        nxt_sh = {sh_ff[6:0], 1'b0};
      end else begin
        nxt_div = div_ff + 5'h1;
      end
    end
    if (clkEn && fsRx && !fsRxD_ff) begin
      nxt_rxS = decode(lawMu, rxCode);
      nxt_rxV = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sh_ff <= 8'h0;
      bits_ff <= 4'h0;
      div_ff <= 5'h0;
      rxS_ff <= 13'h0;
      rxV_ff <= 1'b0;
    end else begin
      sh_ff <= nxt_sh;
      bits_ff <= nxt_bits;
      div_ff <= nxt_div;
      rxS_ff <= nxt_rxS;
      rxV_ff <= nxt_rxV;
    end
  end
  // Driven only mid-word and only once fully powered up
  assign txPcmOe = (bits_ff != 4'h0) && (pwr_ff == PCMC_RUN);
  assign tx_pcm_out = sh_ff[7];
  assign rxSample = rxS_ff;
  assign rxSampleValid = rxV_ff;
endmodule // pcm_compander
`default_nettype wire

//--- sim/pcmc_compander_sva.sv
// Pin-level assertions for the compander block
`default_nettype none
module pcmc_compander_sva (
  // Clock, reset and watched pins
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic power_down_n,
  input wire logic tx_frame_sync,
  input wire logic rx_frame_sync,
  input wire logic [12:0] rxSample,
  input wire logic rxSampleValid,
  input wire logic tx_pcm_out,
  input wire logic txPcmOe,
  input wire logic poweredUp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Checks
  // ********
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  oe_run_only_a: assert property (txPcmOe |-> poweredUp) else $error("pin driven out of run");
  pd_enter_a: assert property ($fell(power_down_n) |-> ##[1:4] !poweredUp) else $error("no power down");
  pd_hold_a: assert property (!power_down_n [*4] |-> !poweredUp && !txPcmOe) else $error("awake in power down");
  word_len_a: assert property ($rose(txPcmOe) |-> ##127 txPcmOe ##1 !txPcmOe) else $error("bad word length");
  bit_hold_a: assert property ($rose(txPcmOe) |=> $stable(tx_pcm_out) [*8]) else $error("bit too short");
  tx_answer_a: assert property ($rose(tx_frame_sync) && poweredUp |-> ##4 txPcmOe) else $error("no word");
  rx_answer_a: assert property ($rose(rx_frame_sync) && poweredUp |-> ##3 rxSampleValid) else $error("no decode");
  oe_start_a: assert property ($rose(txPcmOe) |-> $past(tx_frame_sync, 3)) else $error("word without sync");
  rx_keep_a: assert property ($changed(rxSample) |-> rxSampleValid) else $error("sample moved");
  // Main scenarios reached
  cover property ($rose(poweredUp));
  cover property ($fell(poweredUp) && power_down_n);
  cover property (rxSampleValid);
endmodule // pcmc_compander_sva
bind pcm_compander pcmc_compander_sva pcmc_compander_sva_i (.core_clk, .sys_rst, .power_down_n, .tx_frame_sync,
  .rx_frame_sync, .rxSample, .rxSampleValid, .tx_pcm_out, .txPcmOe, .poweredUp);
`default_nettype wire

//--- sim/pcmc_highway.sv
// Highway model: frame syncs and serial code receiver
`default_nettype none
module pcmc_highway (
  // Clock and frame enable
  input wire logic core_clk,
  input wire logic frameEn,
  // Device pins
  input wire logic tx_pcm_out,
  input wire logic txPcmOe,
  output logic tx_frame_sync,
  output logic rx_frame_sync,
  // Last code word and count
  output logic [7:0] lastCode,
  output logic [7:0] codeCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] frm = 9'h000;
  logic [7:0] ph = 8'h00;
  logic [7:0] sh = 8'h00;
  logic pin;
  // Released pin rests at its pull-up level
  assign pin = txPcmOe ? tx_pcm_out : 1'b1;
  initial begin
    tx_frame_sync = 1'b0;
    rx_frame_sync = 1'b0;
    lastCode = 8'h00;
    codeCnt = 8'h00;
  end
  // Scaled frames keep the run short, still longer than one word
  always @(posedge core_clk) begin
    frm <= (frm == 9'h18f) ? 9'h000 : frm + 9'h001;
    tx_frame_sync <= frameEn && frm < 9'h008;
    rx_frame_sync <= frameEn && frm >= 9'h0c8 && frm < 9'h0d0;
    ph <= txPcmOe ? ph + 8'h01 : 8'h00;
    if (txPcmOe && ph[3:0] == 4'h7) sh <= {sh[6:0], pin};
    if (txPcmOe && ph == 8'h7f) begin
      lastCode <= sh;
      codeCnt <= codeCnt + 8'h01;
    end
  end
endmodule // pcmc_highway
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the compander block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, sys_rst = 1'b1, law_select = 1'b1, power_down_n = 1'b0, frameEn = 1'b0;
  logic tx_frame_sync, rx_frame_sync, tx_pcm_out, txPcmOe, poweredUp, rxSampleValid;
  logic [12:0] txSample = 13'h0000, rxSample;
  logic [7:0] rxCode = 8'hff, lastCode, codeCnt;
  int error_cnt = 0, tests_run = 0;
  // ********
  // Harness
  // ********
  always #5 core_clk = ~core_clk;
  pcm_compander pcm_compander_i (.core_clk, .sys_rst, .law_select, .power_down_n, .tx_frame_sync, .rx_frame_sync,
    .txSample, .rxCode, .rxSample, .rxSampleValid, .tx_pcm_out, .txPcmOe, .poweredUp);
  pcmc_highway pcmc_highway_i (.core_clk, .frameEn, .tx_pcm_out, .txPcmOe, .tx_frame_sync, .rx_frame_sync,
    .lastCode, .codeCnt);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bounded waits, so a dead block ends in a mismatch
  task automatic wait_codes(input int n);
    logic [7:0] c;
    c = codeCnt;
    for (int i = 0; i < 2000 && codeCnt != c + 8'(n); i++) @(posedge core_clk);
    check(codeCnt, 8'(c + 8'(n)));
  endtask
  task automatic wait_valid(input int n);
    for (int i = 0; i < 2000 && n > 0; i++) begin
      @(posedge core_clk);
      if (rxSampleValid === 1'b1) n--;
    end
    check(16'(n), 16'h0000);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic wake_up();
    logic [7:0] c;
    c = codeCnt;
    power_down_n <= 1'b1;
    frameEn <= 1'b1;
    repeat (900) @(posedge core_clk);
    check(poweredUp, 1'b0);
    check(codeCnt, c);
    repeat (1100) @(posedge core_clk);
    check(poweredUp, 1'b1);
  endtask
  // Zero, chord carry and both clip ends, each law
  task automatic encode_table();
    logic [12:0] smp [4] = '{13'h0000, 13'h0020, 13'h0fff, 13'h1000};
    logic [7:0] mu [4] = '{8'hff, 8'he7, 8'h80, 8'h00};
    logic [7:0] al [4] = '{8'hd5, 8'hc5, 8'haa, 8'h2a};
    for (int law = 1; law >= 0; law--) begin
      for (int k = 0; k < 4; k++) begin
        law_select <= law[0];
        txSample <= smp[k];
        wait_codes(2);
        check(lastCode, law ? mu[k] : al[k]);
      end
    end
  endtask
  task automatic decode_pair();
    law_select <= 1'b1;
    rxCode <= 8'hff;
    wait_valid(2);
    check(rxSample, 13'h0000);
    rxCode <= 8'h00;
    wait_valid(2);
    check(rxSample[12], 1'b1);
  endtask
  // Dropped just after a word, so no word is cut short
  task automatic power_off();
    logic [7:0] c;
    wait_codes(1);
    c = codeCnt;
    power_down_n <= 1'b0;
    repeat (1000) @(posedge core_clk);
    check(poweredUp, 1'b0);
    check(txPcmOe, 1'b0);
    check(codeCnt, c);
  endtask
  task automatic idle_off();
    frameEn <= 1'b0;
    repeat (62600) @(posedge core_clk);
    check(poweredUp, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(txPcmOe, 1'b0);
    wake_up();
    encode_table();
    decode_pair();
    power_off();
    wake_up();
    idle_off();
    conclude();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end
endmodule // tb
`default_nettype wire
